// [design/qtx_channel.sv]
// one transmit channel with encoder, word sync, serializer and receive source select
`timescale 1ns/1ns
`default_nettype none
module qtx_channel (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // host character input
   input  wire logic [7:0] tx_char_in,
   input  wire logic       ctrl_char_sel,
   input  wire logic       word_sync_request,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   // static configuration
   input  wire logic       special_char_enable,
   input  wire logic       codec_enable,
   input  wire logic       mult_sel,
   input  wire logic [2:0] tx_input_timing_select,
   output logic            tx_timing_error,
   output logic            comma_detect_enable,
   output logic            reference_clock,
   // serial transmit outputs
   input  wire logic       primary_out_enable,
   input  wire logic       redundant_out_enable,
   output logic            primary_serial_out,
   output logic            primary_out_oe,
   output logic            redundant_serial_out,
   output logic            redundant_out_oe,
   // serial receive side
   input  wire logic       primary_serial_in,
   input  wire logic       redundant_serial_in,
   input  wire logic       rx_source_select,
   input  wire logic [1:0] loopback_select,
   output logic            rx_serial_data,
   output logic            primary_signal_detect,
   output logic            redundant_signal_detect,
   output logic            rx_data_valid,
   output logic [1:0]      recovered_clock_pair
);
   import qtx_pkg::*;

   typedef struct packed {
      qtx_tx_state_type fsm;
      logic [3:0]       bit_cnt;
      logic [3:0]       sync_cnt;
      logic [4:0]       ref_cnt;
      logic             ref_clk;
      logic [9:0]       stage1;
      logic [9:0]       stage2;
      logic             rd;
      logic [9:0]       shift;
      logic             p_out;
      logic             p_oe;
      logic             r_out;
      logic             r_oe;
      logic             rx_data;
      logic             p_det;
      logic             r_det;
      logic             locked;
      logic [1:0]       rclk;
      logic             comma_en;
      logic             timing_err;
   } qtx_chan_state_type;

   qtx_chan_state_type st;
   qtx_chan_state_type next_st;
   logic               slot;
   logic               fifo_valid;
   logic [9:0]         fifo_data;
   logic               p_alive;
   logic               r_alive;
   logic               loop_on;
   logic [10:0]        enc;

   // number of ones in a code word
   function automatic int ones(input logic [9:0] v);
      int n;
      n = 0;
      for (int i = 0; i < 10; i++) begin
         n = n + int'(v[i]);
      end
      return n;
   endfunction

   // 8B/10B encode, returns {next running disparity, code with bit 0 sent first}
   function automatic logic [10:0] enc_8b10b(input logic [7:0] b, input logic k,
                                             input logic rd);
      logic [4:0] x;
      logic [2:0] y;
      logic [5:0] c6;
      logic [3:0] c4;
      logic       rd4;
      logic       k28;
      logic       alt;
      logic [9:0] msb_first;
      logic [9:0] code;
      x   = b[X_HI:0];
      y   = b[Y_HI:Y_LO];
      k28 = k && (x == K28_X);
      c6  = k28 ? K28_6B : ENC6_TABLE[x];
      if (rd && (ones({4'h0, c6}) != BAL6 || c6 == D7_6B)) begin
         c6 = ~c6;
      end
      rd4 = (ones({4'h0, c6}) != BAL6) ? !rd : rd;
      if (k28) begin
         rd4 = 1'b1;
      end
      alt = (y == Y7) && (k || (!rd4 && (x == X17 || x == X18 || x == X20)) ||
                          (rd4 && (x == X11 || x == X13 || x == X14)));
      c4  = alt ? A7_4B : ENC4_TABLE[y];
      if (rd4 && (ones({6'h00, c4}) != BAL4 || c4 == X3_4B)) begin
         c4 = ~c4;
      end
      if (k28 && rd) begin
         c4 = ~c4;
      end
      msb_first = {c6, c4};
      code      = {<<{msb_first}};
      return {(ones(code) != BAL10) ? !rd : rd, code};
   endfunction

   // character buffer between host and encoder, drained once per character
   qtx_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (tx_valid),
      .in_data   ({word_sync_request, ctrl_char_sel, tx_char_in}),
      .in_ready  (tx_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (slot)
   );

   // one-shots on both receive pins, monitored whether selected or not
   qtx_sig_detect u_pdet (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     (primary_serial_in),
      .alive   (p_alive)
   );
   qtx_sig_detect u_rdet (
      .clk_sys (clk_sys),
      .rst     (rst),
      .din     (redundant_serial_in),
      .alive   (r_alive)
   );

   // last bit of a character marks the character boundary
   assign slot    = (st.bit_cnt == LAST_BIT);
   assign loop_on = (loopback_select == LOOPBACK_TX);

   // encoder choice for the character held in stage one
   always_comb begin
      enc = enc_8b10b(IDLE_BYTE, 1'b1, st.rd);
      if (st.fsm == ST_SYNC) begin
         if (next_sync_rev(st.sync_cnt)) begin
            enc = enc_8b10b(IDLE_BYTE, 1'b1, !st.rd);
            enc[10] = st.rd;
         end
      end else if (st.stage1[SYNC_BIT]) begin
         enc = enc_8b10b(IDLE_BYTE, 1'b1, st.rd);
      end else if (!st.stage1[CTRL_BIT]) begin
         enc = enc_8b10b(st.stage1[CHAR_HI:0], 1'b0, st.rd);
      end else if (special_char_enable) begin
         enc = enc_8b10b(st.stage1[CHAR_HI:0], 1'b1, st.rd);
      end else begin
         enc = enc_8b10b(IDLE_BYTE, 1'b1, st.rd);
      end
   end

   // second and fourth characters of a sync sequence reverse disparity
   function automatic logic next_sync_rev(input logic [3:0] cnt);
      logic [3:0] n;
      n = 4'(cnt + 1'b1);
      return (n == SYNC_REV_A) || (n == SYNC_REV_B);
   endfunction

   // next state of the whole channel
   always_comb begin
      next_st = st;
      // bit framing and serial shift
      if (slot) begin
         next_st.bit_cnt = '0;
         next_st.shift   = codec_enable ? st.stage2 : st.stage1;
         next_st.stage1  = fifo_valid ? fifo_data :
                           (codec_enable ? {IDLE_CTRL, IDLE_BYTE} : K285_NEG);
         if (codec_enable) begin
            next_st.stage2 = enc[9:0];
            next_st.rd     = enc[10];
            case (st.fsm)
               ST_DATA: begin
                  if (st.stage1[SYNC_BIT]) begin
                     next_st.fsm      = ST_SYNC;
                     next_st.sync_cnt = '0;
                  end
               end
               ST_SYNC: begin
                  next_st.sync_cnt = 4'(st.sync_cnt + 1'b1);
                  if (next_st.sync_cnt == SYNC_LAST) begin
                     next_st.fsm = ST_DATA;
                  end
               end
               default: begin
                  next_st.fsm = ST_DATA;
               end
            endcase
         end else begin
            next_st.fsm = ST_DATA;
         end
      end else begin
         next_st.bit_cnt = 4'(st.bit_cnt + 1'b1);
         next_st.shift   = {1'b0, st.shift[9:1]};
      end
      // reference clock, half period of five or ten bits
      if (st.ref_cnt == (mult_sel ? HALF_REF_X20 : HALF_REF_X10)) begin
         next_st.ref_cnt = '0;
         next_st.ref_clk = !st.ref_clk;
      end else begin
         next_st.ref_cnt = 5'(st.ref_cnt + 1'b1);
      end
      // output drivers, disabled pins are released
      next_st.p_oe  = primary_out_enable;
      next_st.r_oe  = redundant_out_enable;
      next_st.p_out = primary_out_enable && st.shift[0];
      next_st.r_out = redundant_out_enable && st.shift[0];
      // receive source
      if (loop_on) begin
         next_st.rx_data = st.shift[0];
      end else begin
         next_st.rx_data = rx_source_select ? primary_serial_in : redundant_serial_in;
      end
      // detect and lock status follow the character timing
      if (slot) begin
         next_st.p_det  = p_alive;
         next_st.r_det  = r_alive;
         next_st.locked = loop_on || (rx_source_select ? p_alive : r_alive);
      end
      // recovered clock derived from framing, free of slivers
      next_st.rclk = {st.bit_cnt < HALF_CHAR, !(st.bit_cnt < HALF_CHAR)};
      // configuration status
      next_st.comma_en   = !codec_enable && special_char_enable;
      next_st.timing_err = (tx_input_timing_select != TX_TIMING_REFERENCE_CLOCK);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign primary_serial_out      = st.p_out;
   assign primary_out_oe          = st.p_oe;
   assign redundant_serial_out    = st.r_out;
   assign redundant_out_oe        = st.r_oe;
   assign rx_serial_data          = st.rx_data;
   assign primary_signal_detect   = st.p_det;
   assign redundant_signal_detect = st.r_det;
   assign rx_data_valid           = st.locked;
   assign recovered_clock_pair    = st.rclk;
   assign comma_detect_enable     = st.comma_en;
   assign tx_timing_error         = st.timing_err;
   assign reference_clock         = st.ref_clk;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_char_frame : assert property (slot |=> (!slot)[*8] ##1 !slot ##1 slot)
      else $error("character slot not ten bits apart");
   a_lsb_first : assert property (slot ##1 primary_out_enable |=>
      primary_serial_out == $past(st.shift[0]))
      else $error("first bit of character not its lsb");
   a_idle_code : assert property ((slot && codec_enable && st.fsm == ST_DATA &&
      !st.stage1[SYNC_BIT] && st.stage1[CTRL_BIT] && !special_char_enable) |=>
      (st.stage2 == K285_NEG || st.stage2 == K285_POS))
      else $error("idle request did not yield K28.5");
   a_sync_length : assert property ($rose(st.fsm == ST_SYNC) |->
      ##149 (st.fsm == ST_SYNC) ##1 (st.fsm == ST_DATA))
      else $error("word sync sequence length wrong");
   a_sync_idle : assert property ((slot && codec_enable && st.fsm == ST_SYNC) |=>
      (st.stage2 == K285_NEG || st.stage2 == K285_POS))
      else $error("word sync character not K28.5");
   a_ref_period : assert property (($rose(reference_clock) && !mult_sel) ##1
      (!mult_sel)[*5] |-> $fell(reference_clock))
      else $error("reference clock half period not five bits");
   a_loop_source : assert property (loop_on |=> rx_serial_data == $past(st.shift[0]))
      else $error("loopback did not route transmitter");
   a_rx_select : assert property ((!loop_on && rx_source_select) |=>
      rx_serial_data == $past(primary_serial_in))
      else $error("primary input not selected");
   a_out_enable : assert property (!primary_out_enable |=>
      (!primary_out_oe && !primary_serial_out))
      else $error("disabled primary output still driven");
   a_comma_enable : assert property ((!codec_enable && special_char_enable) |=>
      comma_detect_enable)
      else $error("comma detection not enabled in bypass");
   a_valid_lock : assert property ((slot && !loop_on && rx_source_select && !p_alive) |=>
      !rx_data_valid)
      else $error("data flagged valid without signal");
endmodule
`default_nettype wire

// [design/qtx_fifo.sv]
// small synchronous fifo holding host characters ahead of the encoder
`timescale 1ns/1ns
`default_nettype none
module qtx_fifo #(
   parameter int WIDTH = qtx_pkg::FIFO_WIDTH,
   parameter int DEPTH = qtx_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // filling side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // draining side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   import qtx_pkg::*;
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [CW-1:0]               count;
      logic                        full;
      logic                        empty;
   } qtx_fifo_state_type;
   qtx_fifo_state_type st;
   qtx_fifo_state_type next_st;
   logic push;
   logic pop;

   // handshakes on both sides
   assign push      = in_valid && !st.full;
   assign pop       = out_ready && !st.empty;
   assign in_ready  = !st.full;
   assign out_valid = !st.empty;
   assign out_data  = st.mem[st.rd_ptr];

   // pointer, count and flag update
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data;
         next_st.wr_ptr = PW'((st.wr_ptr + 1'b1) % DEPTH);
      end
      if (pop) begin
         next_st.rd_ptr = PW'((st.rd_ptr + 1'b1) % DEPTH);
      end
      next_st.count = CW'(st.count + CW'(push) - CW'(pop));
      next_st.full  = (next_st.count == CW'(DEPTH));
      next_st.empty = (next_st.count == '0);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st       <= '0;
         st.empty <= 1'b1;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// [design/qtx_pkg.sv]
// shared constants, tables and types for the serial transmit channel
package qtx_pkg;
   // timing: one serial bit per clk_sys cycle
   localparam int CLK_PERIOD_NS = 100;
   localparam int BIT_PERIOD_NS = 100;
   localparam int SDET_MIN_BITS = 40;
   localparam int SDET_MAX_BITS = 80;
   localparam int SDET_TIME_NS  = (SDET_MIN_BITS + SDET_MAX_BITS) / 2 * BIT_PERIOD_NS;
   localparam int SDET_CYCLES   = SDET_TIME_NS / CLK_PERIOD_NS;
   localparam int SDET_CNT_W    = 7;
   // fifo shape and word layout
   localparam int FIFO_WIDTH = 10;
   localparam int FIFO_DEPTH = 8;
   localparam int CHAR_HI    = 7;
   localparam int CTRL_BIT   = 8;
   localparam int SYNC_BIT   = 9;
   // character framing and reference divider
   localparam logic [3:0] LAST_BIT     = 4'h9;
   localparam logic [3:0] HALF_CHAR    = 4'h5;
   localparam logic [4:0] HALF_REF_X10 = 5'h04;
   localparam logic [4:0] HALF_REF_X20 = 5'h09;
   // word sync sequence
   localparam logic [3:0] SYNC_LAST  = 4'hF;
   localparam logic [3:0] SYNC_REV_A = 4'h1;
   localparam logic [3:0] SYNC_REV_B = 4'h3;
   // mode codes
   localparam logic [1:0] LOOPBACK_TX      = 2'h2;
   localparam logic [2:0] TX_TIMING_REFERENCE_CLOCK = 3'h0;
   // code points
   localparam logic [7:0] IDLE_BYTE = 8'hBC;
   localparam logic [1:0] IDLE_CTRL = 2'h1;
   localparam logic [9:0] K285_NEG  = 10'h17C;
   localparam logic [9:0] K285_POS  = 10'h283;
   localparam int X_HI = 4;
   localparam int Y_LO = 5;
   localparam int Y_HI = 7;
   localparam int BAL6  = 3;
   localparam int BAL4  = 2;
   localparam int BAL10 = 5;
   localparam logic [4:0] K28_X = 5'h1C;
   localparam logic [4:0] X11 = 5'h0B;
   localparam logic [4:0] X13 = 5'h0D;
   localparam logic [4:0] X14 = 5'h0E;
   localparam logic [4:0] X17 = 5'h11;
   localparam logic [4:0] X18 = 5'h12;
   localparam logic [4:0] X20 = 5'h14;
   localparam logic [2:0] Y7  = 3'h7;
   localparam logic [5:0] K28_6B = 6'h0F;
   localparam logic [5:0] D7_6B  = 6'h38;
   localparam logic [3:0] X3_4B  = 4'hC;
   localparam logic [3:0] A7_4B  = 4'h7;
   // negative-disparity codes, first transmitted bit in the msb
   localparam logic [5:0] ENC6_TABLE [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] ENC4_TABLE [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
   // transmit sequencing
   typedef enum logic {
      ST_DATA = 1'b0,
      ST_SYNC = 1'b1
   } qtx_tx_state_type;
endpackage

// [design/qtx_sig_detect.sv]
// retriggerable one-shot that reports transitions on a serial input
`timescale 1ns/1ns
`default_nettype none
module qtx_sig_detect (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // monitored line and result
   input  wire logic din,
   output logic      alive
);
   import qtx_pkg::*;
   typedef struct packed {
      logic                  prev;
      logic [SDET_CNT_W-1:0] cnt;
      logic                  alive;
   } qtx_sdet_state_type;
   qtx_sdet_state_type st;
   qtx_sdet_state_type next_st;

   assign alive = st.alive;

   // any edge restarts the time-out; density is not judged
   always_comb begin
      next_st      = st;
      next_st.prev = din;
      if (din != st.prev) begin
         next_st.cnt   = '0;
         next_st.alive = 1'b1;
      end else if (st.cnt == SDET_CNT_W'(SDET_CYCLES - 1)) begin
         next_st.alive = 1'b0;
      end else begin
         next_st.cnt = SDET_CNT_W'(st.cnt + 1'b1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_sdet_timeout : assert property (@(posedge clk_sys) disable iff (rst)
      (st.alive && din == st.prev && st.cnt == SDET_CNT_W'(SDET_CYCLES - 1)) |=> !st.alive)
      else $error("signal detect did not time out");
   a_sdet_retrig : assert property (@(posedge clk_sys) disable iff (rst)
      (din != st.prev) |=> (st.alive && st.cnt == '0))
      else $error("signal detect not retriggered by edge");
endmodule
`default_nettype wire

// [test/qtx_remote_model.sv]
// remote serial transmitter model feeding the channel's two receive lines
`timescale 1ns/1ns
`default_nettype none
module qtx_remote_model (
   // clock
   input  wire logic clk_sys,
   // which lines carry traffic
   input  wire logic p_active,
   input  wire logic r_active,
   // serial lines towards the channel
   output logic      p_line,
   output logic      r_line
);
   logic [6:0] lfsr = 7'h5A;
   // pseudo random bits while active, a quiet steady line otherwise
   always_ff @(posedge clk_sys) begin
      lfsr   <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      p_line <= p_active ? lfsr[0] : 1'b0;
      r_line <= r_active ? lfsr[3] : 1'b0;
   end
endmodule
`default_nettype wire

// [test/quad_tx_encode_word_sync_rx_select_tb_top.sv]
// self-checking bench for one transmit channel
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected t=%0t got %0h exp %0h", $time, a, b); end end
module quad_tx_encode_word_sync_rx_select_tb_top;
   import qtx_pkg::*;
   logic       clk_sys = 0, rst = 1, tx_valid = 0, tx_ready, ctrl_char_sel = 0;
   logic       word_sync_request = 0, special_char_enable = 0, codec_enable = 0, mult_sel = 0;
   logic [7:0] tx_char_in = 8'h00;
   logic [2:0] tx_input_timing_select = 3'h0;
   logic [1:0] loopback_select = 2'h0, recovered_clock_pair;
   logic       tx_timing_error, comma_detect_enable, reference_clock, primary_serial_out;
   logic       primary_out_enable = 1, redundant_out_enable = 1, primary_out_oe;
   logic       redundant_serial_out, redundant_out_oe, primary_serial_in, redundant_serial_in;
   logic       rx_source_select = 1, rx_serial_data, primary_signal_detect;
   logic       redundant_signal_detect, rx_data_valid, p_act = 0, r_act = 0, src, pe, re, lb;
   int         n_fail = 0, tests_run = 0, cycles = 0, i, n, bad, eq, refused, s;
   logic [9:0] w;
   logic [9:0] acc[$];
   logic       bits[$];
   qtx_channel i_qtx_channel (.*);
   qtx_remote_model i_qtx_remote_model (.clk_sys(clk_sys), .p_active(p_act),
      .r_active(r_act), .p_line(primary_serial_in), .r_line(redundant_serial_in));
   // clock and hang guard
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   // record the primary serial stream
   always @(negedge clk_sys) if (!rst) bits.push_back(primary_serial_out);
   function automatic logic [9:0] char_at(int i);
      for (int j = 0; j < 10; j++) char_at[j] = bits[i+j];
   endfunction
   function automatic int align(int s);
      for (int i = s; i + 10 <= bits.size(); i++)
         if (char_at(i) === K285_NEG || char_at(i) === K285_POS) return i;
      return s;
   endfunction
   // count non-idle characters and same-disparity neighbours
   function automatic void scan(int s, output int bad, output int eq);
      logic [9:0] c, p;
      bad = 0; eq = 0; p = 10'h000;
      for (int i = s; i + 10 <= bits.size(); i += 10) begin
         c = char_at(i);
         if (c !== K285_NEG && c !== K285_POS) bad++;
         else if (c === p) eq++;
         p = c;
      end
   endfunction
   function automatic bit has_seq();
      bit ok;
      for (int i = 0; i + 10 * acc.size() <= bits.size(); i++) begin
         ok = 1;
         foreach (acc[k]) if (char_at(i + 10 * k) !== acc[k]) ok = 0;
         if (ok) return 1;
      end
      return 0;
   endfunction
   // static modes change only under reset
   task automatic setup(input logic cd, input logic sp, input logic ms);
      @(negedge clk_sys);
      rst = 1; codec_enable = cd; special_char_enable = sp; mult_sel = ms;
      repeat (20) @(negedge clk_sys);
      rst = 0;
      bits.delete();
   endtask
   task automatic push(input logic [9:0] v);
      @(negedge clk_sys);
      {word_sync_request, ctrl_char_sel, tx_char_in} = v; tx_valid = 1;
      if (tx_ready === 1'b1) acc.push_back(v); else refused++;
   endtask
   task automatic edge_up(output int n);
      n = 0;
      while (reference_clock !== 1'b0 && n < 50) begin @(negedge clk_sys); n++; end
      while (reference_clock !== 1'b1 && n < 50) begin @(negedge clk_sys); n++; end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hAB98));
      // bypass: raw words, fifo filled until refused, lsb first
      setup(0, 1, 0);
      edge_up(n); edge_up(n);
      `CHK(n, 10)
      `CHK(comma_detect_enable, 1'b1)
      refused = 0;
      for (i = 0; i < 14; i++) push(10'($urandom));
      @(negedge clk_sys) tx_valid = 0;
      `CHK(refused > 0, 1'b1)
      repeat (220) @(negedge clk_sys);
      `CHK(tx_ready, 1'b1)
      `CHK(has_seq(), 1'b1)
      // encode: control characters give idles whatever the byte
      setup(1, 0, 1);
      edge_up(n); edge_up(n);
      `CHK(n, 20)
      `CHK(comma_detect_enable, 1'b0)
      for (i = 0; i < 6; i++) push({2'h1, 8'($urandom)});
      @(negedge clk_sys) tx_valid = 0;
      repeat (150) @(negedge clk_sys);
      scan(align(0), bad, eq);
      `CHK(bad, 0)
      `CHK(eq, 0)
      // one sync request brings disparity reversals among idles
      s = bits.size();
      push({2'h3, 8'($urandom)});
      @(negedge clk_sys) tx_valid = 0;
      repeat (260) @(negedge clk_sys);
      scan(align(s), bad, eq);
      `CHK(bad, 0)
      `CHK(eq > 0, 1'b1)
      // special mode: the byte picks the K character, K28.0 here
      setup(1, 1, 0);
      push({2'h1, 8'h1C});
      @(negedge clk_sys) tx_valid = 0;
      repeat (60) @(negedge clk_sys);
      acc.delete();
      acc.push_back(10'h0BC);
      `CHK(has_seq(), 1'b1)
      // receive source, loopback and output enables at random
      p_act = 1; r_act = 1;
      for (i = 0; i < 60; i++) begin
         @(negedge clk_sys);
         if (i > 0) begin
            if (lb) src = primary_serial_out;
            `CHK(rx_serial_data, src)
            `CHK(primary_out_oe, pe)
            `CHK(redundant_out_oe, re)
         end
         loopback_select = 2'($urandom); rx_source_select = 1'($urandom);
         primary_out_enable = (loopback_select == LOOPBACK_TX) | 1'($urandom);
         redundant_out_enable = 1'($urandom);
         lb = (loopback_select == LOOPBACK_TX);
         pe = primary_out_enable; re = redundant_out_enable;
         src = rx_source_select ? primary_serial_in : redundant_serial_in;
      end
      // signal detect as a one-shot, lock follows it
      loopback_select = 2'h0; rx_source_select = 1; r_act = 0;
      repeat (100) @(negedge clk_sys);
      `CHK(primary_signal_detect, 1'b1)
      `CHK(redundant_signal_detect, 1'b0)
      `CHK(rx_data_valid, 1'b1)
      p_act = 0;
      repeat (30) @(negedge clk_sys);
      `CHK(primary_signal_detect, 1'b1)
      repeat (70) @(negedge clk_sys);
      `CHK(primary_signal_detect, 1'b0)
      `CHK(rx_data_valid, 1'b0)
      // unsupported input timing codes are flagged
      tx_input_timing_select = 3'($urandom_range(7, 1));
      repeat (3) @(negedge clk_sys);
      `CHK(tx_timing_error, 1'b1)
      tx_input_timing_select = TX_TIMING_REFERENCE_CLOCK;
      repeat (3) @(negedge clk_sys);
      `CHK(tx_timing_error, 1'b0)
      give_verdict();
   end
endmodule
`default_nettype wire
